// *** core/smd_msg_decoder.sv ***
// smd_msg_decoder: decodes controller-to-device 0xC3 messages
// assumes: link bytes arrive on link_clk; all else on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "smd_consts.svh"

// How it works
// - control frame is C3, count four
// - second byte: reset, power down, pin clear
// - echoed status fields decoded as documented
// - config frame: flags, data high, low, address
// - config bit five direction, four:zero register
// - status resent on timeout, dropped after 32
module smd_msg_decoder #(
    parameter int unsigned ACK_TIMEOUT_CYC = `SMD_ACK_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic link_byte_valid,
    input wire logic link_byte_first,
    input wire logic [7:0] link_byte,
    input wire logic host_wake_event,
    input wire logic status_change,
    input wire smd_pkg::smd_status_type status_in,
    input wire logic status_tx_ready,
    output logic status_tx_valid,
    output smd_pkg::smd_status_type status_tx_data,
    output logic status_acked,
    output logic status_abandon,
    output logic port_reset_pulse,
    output logic power_down_request,
    output logic wake_pin_clear,
    output logic wake_out_pin_b,
    output logic cfg_valid,
    output logic cfg_write,
    output logic [4:0] cfg_reg_addr,
    output logic [15:0] cfg_data,
    output logic [4:0] cfg_phy_addr,
    output logic ack_valid,
    output smd_pkg::smd_status_type ack_echo,
    output logic msg_error
);

    // *************************************************************
    // helpers
    // *************************************************************
    function automatic smd_pkg::smd_kind_type msg_kind(
        input logic [7:0] a);
        msg_kind = smd_pkg::smd_kind_type'(
            {a[`SMD_CFG_FLAG_BIT], a[`SMD_CMD_ACK_BIT]});
    endfunction : msg_kind

    function automatic logic low_zero(input logic [7:0] a);
        low_zero = (a[5:0] == 6'h00);
    endfunction : low_zero

    // *************************************************************
    // link side and crossing
    // *************************************************************
    logic frame_toggle;
    smd_pkg::smd_frame_type frame_link;

    smd_rx_frame u_rx (
        .link_clk(link_clk),
        .rst_b(rst_b),
        .link_byte_valid(link_byte_valid),
        .link_byte_first(link_byte_first),
        .link_byte(link_byte),
        .frame_toggle(frame_toggle),
        .frame_out(frame_link)
    );

    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic msg_vld_reg;
    smd_pkg::smd_frame_type msg_reg;

    // toggle synchroniser; word is stable long before the edge lands
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            msg_vld_reg <= 1'b0;
            msg_reg <= '0;
        end else begin
            tog_s1_reg <= frame_toggle;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            msg_vld_reg <= tog_s2_reg ^ tog_s3_reg;
            if (tog_s2_reg ^ tog_s3_reg) msg_reg <= frame_link;
        end
    end

    // *************************************************************
    // decode
    // *************************************************************
    smd_pkg::smd_kind_type kind;
    logic good;
    logic is_ctl;
    logic is_ack;
    logic is_cfg;

    // reserved bits checked so a malformed frame cannot act
    assign kind = msg_kind(msg_reg.addr_ctl);
    assign good = msg_vld_reg && !msg_reg.bad;
    assign is_ctl = good && kind == smd_pkg::SMD_KIND_CTL
        && low_zero(msg_reg.addr_ctl);
    assign is_ack = good && kind == smd_pkg::SMD_KIND_ACK
        && low_zero(msg_reg.addr_ctl);
    assign is_cfg = good && kind == smd_pkg::SMD_KIND_CFG;

    // control command actions; power down follows the latest command
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_reset_pulse <= 1'b0;
            power_down_request <= 1'b0;
            wake_pin_clear <= 1'b0;
        end else begin
            port_reset_pulse <= is_ctl
                && msg_reg.byte_two[`SMD_PORT_RST_BIT];
            wake_pin_clear <= is_ctl
                && msg_reg.byte_two[`SMD_PIN_CLEAR_BIT];
            if (is_ctl) begin
                power_down_request <=
                    msg_reg.byte_two[`SMD_PWR_DOWN_BIT];
            end
        end
    end

    // wake pin: a new wake event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_out_pin_b <= 1'b1;
        end else if (host_wake_event) begin
            wake_out_pin_b <= 1'b0;
        end else if (is_ctl && msg_reg.byte_two[`SMD_PIN_CLEAR_BIT]) begin
            wake_out_pin_b <= 1'b1;
        end
    end

    // register access request handed to the register file
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_valid <= 1'b0;
            cfg_write <= 1'b0;
            cfg_reg_addr <= 5'h00;
            cfg_data <= 16'h0000;
            cfg_phy_addr <= 5'h00;
        end else begin
            cfg_valid <= is_cfg;
            if (is_cfg) begin
                cfg_write <= msg_reg.addr_ctl[`SMD_RW_BIT];
                cfg_reg_addr <=
                    msg_reg.addr_ctl[`SMD_REG_ADDR_MSB:0];
                cfg_data <= {msg_reg.byte_one, msg_reg.byte_two};
                cfg_phy_addr <= msg_reg.byte_three[4:0];
            end
        end
    end

    // echoed status of an acknowledge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_valid <= 1'b0;
            ack_echo <= '0;
        end else begin
            ack_valid <= is_ack;
            if (is_ack) begin
                ack_echo <= '{
                    host_wake_indication:
                        msg_reg.byte_one[`SMD_HOST_WAKE_BIT],
                    reset_complete_flag:
                        msg_reg.byte_two[`SMD_RST_DONE_BIT],
                    cable_disconnected_flag:
                        msg_reg.byte_two[`SMD_CABLE_DIS_BIT],
                    link_up_flag: msg_reg.byte_two[`SMD_LINK_UP_BIT],
                    full_duplex_flag: msg_reg.byte_two[`SMD_DUPLEX_BIT],
                    link_speed_field:
                        msg_reg.byte_two[`SMD_SPEED_MSB:0]};
            end
        end
    end

    // anything delivered that none of the three kinds accepted
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) msg_error <= 1'b0;
        else msg_error <= msg_vld_reg && !(is_ctl || is_ack || is_cfg);
    end

    // *************************************************************
    // status message retransmission
    // *************************************************************
    smd_pkg::smd_state_type state_reg;
    logic change_pend_reg;
    logic [5:0] retry_reg;
    logic [19:0] timer_reg;
    logic timeout;
    logic start;

    assign start = state_reg == smd_pkg::SMD_ST_IDLE && change_pend_reg;
    assign timeout = timer_reg == 20'(ACK_TIMEOUT_CYC - 1);
    assign status_tx_valid = state_reg == smd_pkg::SMD_ST_SEND;

    // pending change; a change in the starting cycle is kept
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) change_pend_reg <= 1'b0;
        else change_pend_reg <= status_change || (change_pend_reg && !start);
    end

    // acknowledge timer, runs only while waiting
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) timer_reg <= 20'h0_0000;
        else if (state_reg != smd_pkg::SMD_ST_WAIT) timer_reg <= 20'h0_0000;
        else timer_reg <= timer_reg + 20'h0_0001;
    end

    // send, wait, resend up to the retry limit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= smd_pkg::SMD_ST_IDLE;
            retry_reg <= 6'h00;
            status_tx_data <= '0;
            status_acked <= 1'b0;
            status_abandon <= 1'b0;
        end else begin
            status_acked <= 1'b0;
            status_abandon <= 1'b0;
            unique case (state_reg)
                smd_pkg::SMD_ST_IDLE: begin
                    if (start) begin
                        state_reg <= smd_pkg::SMD_ST_SEND;
                        retry_reg <= 6'h00;
                        status_tx_data <= status_in;
                    end
                end
                smd_pkg::SMD_ST_SEND: begin
                    if (status_tx_ready) state_reg <= smd_pkg::SMD_ST_WAIT;
                end
                smd_pkg::SMD_ST_WAIT: begin
                    if (is_ack) begin
                        state_reg <= smd_pkg::SMD_ST_IDLE;
                        status_acked <= 1'b1;
                    end else if (timeout) begin
                        if (retry_reg == `SMD_MAX_RETRIES) begin
                            state_reg <= smd_pkg::SMD_ST_IDLE;
                            status_abandon <= 1'b1;
                        end else begin
                            state_reg <= smd_pkg::SMD_ST_SEND;
                            retry_reg <= retry_reg + 6'h01;
                        end
                    end
                end
                default: state_reg <= smd_pkg::SMD_ST_IDLE;
            endcase
        end
    end

    // *************************************************************
    // checks
    // *************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_ctl_msg;
        is_ctl;
    endsequence

    sequence s_wait_ack;
        state_reg == smd_pkg::SMD_ST_WAIT ##0 is_ack;
    endsequence

    a_port_reset: assert property (
        s_ctl_msg ##0 msg_reg.byte_two[7] |=> port_reset_pulse)
        else $error("port reset not requested");

    a_power_down_level: assert property (
        s_ctl_msg |=> power_down_request == $past(msg_reg.byte_two[6])
            ##1 power_down_request == $past(power_down_request) || is_ctl)
        else $error("power down does not follow control");

    a_wake_clear: assert property (
        s_ctl_msg ##0 msg_reg.byte_two[0] && !host_wake_event
            |=> wake_out_pin_b && wake_pin_clear)
        else $error("wake pin not cleared");

    a_cfg_fields: assert property (
        is_cfg |=> cfg_valid && cfg_write == $past(msg_reg.addr_ctl[5])
            && cfg_reg_addr == $past(msg_reg.addr_ctl[4:0]))
        else $error("config fields wrong");

    a_kind_only_flags: assert property (
        good && msg_reg.addr_ctl[7:6] == 2'b01 |=> msg_error && !cfg_valid)
        else $error("odd flag pair accepted");

    a_ack_ends_wait: assert property (
        s_wait_ack |=> state_reg == smd_pkg::SMD_ST_IDLE && status_acked)
        else $error("acknowledge did not end wait");

    a_retry_limit: assert property (
        status_abandon |-> $past(retry_reg) == 6'h20
            && $past(timeout) && retry_reg <= 6'h20)
        else $error("abandon outside the retry limit");

    a_resend_timeout: assert property (
        state_reg == smd_pkg::SMD_ST_WAIT && timeout && !is_ack
            && retry_reg != 6'h20 |=> status_tx_valid
            && retry_reg == $past(retry_reg) + 6'h01)
        else $error("status not resent after timeout");

endmodule : smd_msg_decoder
`default_nettype wire

// *** core/smd_consts.svh ***
// smd_consts.svh: offsets, field positions and timing counts
// assumes: included by bare name from the two modules
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH

// *****************************************************************
// frame header
// *****************************************************************
`define SMD_CMD_CODE 8'hC3
`define SMD_BYTE_COUNT 8'h04
`define SMD_LAST_BYTE_IDX 3'h5

// *****************************************************************
// address and control byte
// *****************************************************************
`define SMD_CFG_FLAG_BIT 7
`define SMD_CMD_ACK_BIT 6
`define SMD_RW_BIT 5
`define SMD_REG_ADDR_MSB 4

// *****************************************************************
// control command second byte
// *****************************************************************
`define SMD_PORT_RST_BIT 7
`define SMD_PWR_DOWN_BIT 6
`define SMD_PIN_CLEAR_BIT 0

// *****************************************************************
// echoed status bytes
// *****************************************************************
`define SMD_HOST_WAKE_BIT 5
`define SMD_RST_DONE_BIT 7
`define SMD_CABLE_DIS_BIT 4
`define SMD_LINK_UP_BIT 3
`define SMD_DUPLEX_BIT 2
`define SMD_SPEED_MSB 1

// *****************************************************************
// status retransmission
// *****************************************************************
`define SMD_MAX_RETRIES 6'h20
`define SMD_ACK_TIMEOUT_NS 100000
`define SMD_CLK_PERIOD_NS 5
`define SMD_ACK_TIMEOUT_CYC (`SMD_ACK_TIMEOUT_NS / `SMD_CLK_PERIOD_NS)

`endif

// *** core/smd_pkg.sv ***
// smd_pkg: types shared by the link side and the decoder
// assumes: nothing beyond the constants header
package smd_pkg;

    // one received block write, already stripped of its header
    typedef struct packed {
        logic bad;
        logic [7:0] addr_ctl;
        logic [7:0] byte_one;
        logic [7:0] byte_two;
        logic [7:0] byte_three;
    } smd_frame_type;

    // device status as sent out and as echoed back
    typedef struct packed {
        logic host_wake_indication;
        logic reset_complete_flag;
        logic cable_disconnected_flag;
        logic link_up_flag;
        logic full_duplex_flag;
        logic [1:0] link_speed_field;
    } smd_status_type;

    // message kind from the two top flag bits
    typedef enum logic [1:0] {
        SMD_KIND_CFG = 2'b00,
        SMD_KIND_ODD = 2'b01,
        SMD_KIND_CTL = 2'b10,
        SMD_KIND_ACK = 2'b11
    } smd_kind_type;

    typedef enum logic [2:0] {
        SMD_ST_IDLE = 3'b001,
        SMD_ST_SEND = 3'b010,
        SMD_ST_WAIT = 3'b100
    } smd_state_type;

endpackage : smd_pkg

// *** core/smd_rx_frame.sv ***
// smd_rx_frame: gathers one block write on the link clock
// assumes: a byte layer on link_clk marks the command byte as first
`timescale 1ns/1ps
`default_nettype none
`include "smd_consts.svh"

module smd_rx_frame (
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic link_byte_valid,
    input wire logic link_byte_first,
    input wire logic [7:0] link_byte,
    output logic frame_toggle,
    output smd_pkg::smd_frame_type frame_out
);

    logic [2:0] idx_reg;
    logic hdr_ok_reg;
    logic [7:0] addr_reg;
    logic [7:0] one_reg;
    logic [7:0] two_reg;
    logic last_byte;

    assign last_byte = link_byte_valid && !link_byte_first
        && idx_reg == `SMD_LAST_BYTE_IDX;

    // byte position; a first byte restarts, no edge after frame needed
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_reg <= 3'h0;
            hdr_ok_reg <= 1'b0;
        end else if (link_byte_valid && link_byte_first) begin
            idx_reg <= 3'h1;
            hdr_ok_reg <= (link_byte == `SMD_CMD_CODE);
        end else if (link_byte_valid && idx_reg != 3'h0
                     && idx_reg <= `SMD_LAST_BYTE_IDX) begin
            idx_reg <= idx_reg + 3'h1; // saturates one past the end
            if (idx_reg == 3'h1) begin
                hdr_ok_reg <= hdr_ok_reg
                    && (link_byte == `SMD_BYTE_COUNT);
            end
        end
    end

    // data bytes one to three
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg <= 8'h00;
            one_reg <= 8'h00;
            two_reg <= 8'h00;
        end else if (link_byte_valid && !link_byte_first) begin
            if (idx_reg == 3'h2) addr_reg <= link_byte;
            if (idx_reg == 3'h3) one_reg <= link_byte;
            if (idx_reg == 3'h4) two_reg <= link_byte;
        end
    end

    // publish on the fourth data byte; word held until next frame
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_toggle <= 1'b0;
            frame_out <= '0;
        end else if (last_byte) begin
            frame_toggle <= ~frame_toggle;
            frame_out <= '{bad: !hdr_ok_reg, addr_ctl: addr_reg,
                           byte_one: one_reg, byte_two: two_reg,
                           byte_three: link_byte};
        end
    end

    default clocking @(posedge link_clk); endclocking
    default disable iff (!rst_b);

    a_publish_on_sixth: assert property (
        $changed(frame_toggle) |-> $past(last_byte))
        else $error("frame published before its sixth byte");

    a_header_checked: assert property (
        last_byte && !hdr_ok_reg |=> frame_out.bad)
        else $error("bad header not marked on frame");

endmodule : smd_rx_frame
`default_nettype wire

// *** test/smd_host_model.sv ***
// smd_host_model: controller side of the link, sends block writes
// assumes: go pulses once per frame, frames spaced by the bench
`timescale 1ns/1ps
`default_nettype none

module smd_host_model (
    input wire logic rst_b,
    input wire logic go,
    input wire logic [47:0] frame_bytes,
    input wire logic [2:0] n_bytes,
    output logic link_clk,
    output logic link_byte_valid,
    output logic link_byte_first,
    output logic [7:0] link_byte
);
    // *************************************************************
    // byte driver
    // *************************************************************
    // one process owns the link: a frame never overlaps reset clocking
    initial begin
        link_clk = 1'b0;
        link_byte_valid = 1'b0;
        link_byte_first = 1'b0;
        link_byte = 8'h00;
        #1.7;
        // clock only runs during reset and inside frames, odd phase
        while (rst_b !== 1'b1) begin
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        // whole frame, command byte marked first
        forever begin
            // level wait, so a go raised during reset is not lost
            wait (go === 1'b1);
            link_byte = frame_bytes[47 -: 8];
            link_byte_valid = 1'b1;
            link_byte_first = 1'b1;
            for (int i = 0; i < n_bytes; i++) begin
                #3 link_clk = 1'b1;
                #1 link_byte_first = 1'b0;
                if (i + 1 < n_bytes) begin
                    link_byte = frame_bytes[39 - 8 * i -: 8];
                end else begin
                    // released line: no stale value left behind
                    link_byte_valid = 1'b0;
                    link_byte = ~link_byte;
                end
                #2 link_clk = 1'b0;
            end
            wait (go === 1'b0);
        end
    end
endmodule : smd_host_model
`default_nettype wire

// *** test/smd_msg_decoder_bench.sv ***
// smd_msg_decoder_bench: frame calls with expected pulses and fields
// assumes: design files and smd_host_model compiled before this
`timescale 1ns/1ps
`default_nettype none

module smd_msg_decoder_bench;
    logic sys_clk, rst_b, go, host_wake_event, status_change;
    logic status_tx_ready, prev_valid;
    logic [47:0] frame_bytes;
    logic [2:0] n_bytes;
    logic [6:0] seen;
    wire logic link_clk, link_byte_valid, link_byte_first;
    wire logic [7:0] link_byte;
    smd_pkg::smd_status_type status_in, status_tx_data, ack_echo;
    logic status_tx_valid, status_acked, status_abandon, port_reset_pulse;
    logic power_down_request, wake_pin_clear, wake_out_pin_b, cfg_valid;
    logic cfg_write, ack_valid, msg_error;
    logic [4:0] cfg_reg_addr, cfg_phy_addr;
    logic [15:0] cfg_data;
    wire logic [6:0] pulses;
    int n_mismatch, n_checks, n_sends;
    logic [47:0] bad_f [6];

    assign pulses = {port_reset_pulse, wake_pin_clear, cfg_valid,
        ack_valid, msg_error, status_acked, status_abandon};

    smd_msg_decoder #(.ACK_TIMEOUT_CYC(20)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk),
        .link_byte_valid(link_byte_valid),
        .link_byte_first(link_byte_first), .link_byte(link_byte),
        .host_wake_event(host_wake_event), .status_change(status_change),
        .status_in(status_in), .status_tx_ready(status_tx_ready),
        .status_tx_valid(status_tx_valid), .status_tx_data(status_tx_data),
        .status_acked(status_acked), .status_abandon(status_abandon),
        .port_reset_pulse(port_reset_pulse),
        .power_down_request(power_down_request),
        .wake_pin_clear(wake_pin_clear), .wake_out_pin_b(wake_out_pin_b),
        .cfg_valid(cfg_valid), .cfg_write(cfg_write),
        .cfg_reg_addr(cfg_reg_addr), .cfg_data(cfg_data),
        .cfg_phy_addr(cfg_phy_addr), .ack_valid(ack_valid),
        .ack_echo(ack_echo), .msg_error(msg_error)
    );

    smd_host_model u_host (
        .rst_b(rst_b), .go(go), .frame_bytes(frame_bytes),
        .n_bytes(n_bytes), .link_clk(link_clk),
        .link_byte_valid(link_byte_valid),
        .link_byte_first(link_byte_first), .link_byte(link_byte)
    );

    // *************************************************************
    // clock, pulse catcher and helpers
    // *************************************************************
    always #2.5 sys_clk = ~sys_clk;

    // sticky pulse record, since each pulse stands one cycle only
    always @(posedge sys_clk) begin
        seen = seen | pulses;
        if (status_tx_valid === 1'b1 && prev_valid !== 1'b1) n_sends++;
        prev_valid = status_tx_valid;
    end

    function automatic logic [47:0] fr(input logic [7:0] a, b1, b2, b3);
        return {8'hC3, 8'h04, a, b1, b2, b3};
    endfunction : fr

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_pulse(input logic [6:0] got, input logic [6:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t pulses got %h exp %h", $time, got, exp);
        end
    endtask : chk_pulse

    // latency is fixed by the hand-over, so a fixed wait is enough
    task automatic send(input logic [47:0] f, input logic [2:0] n,
        input logic [6:0] exp);
        frame_bytes = f;
        n_bytes = n;
        seen = 7'h00;
        go = 1'b1;
        @(posedge sys_clk) #1 go = 1'b0;
        repeat (24) @(posedge sys_clk);
        #1 chk_pulse(seen, exp);
    endtask : send

    task automatic kick(input logic [6:0] st);
        status_in = st;
        status_change = 1'b1;
        @(posedge sys_clk) #1 status_change = 1'b0;
    endtask : kick

    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // watchdog, about ten times the expected run
    initial begin
        #60000;
        n_mismatch++;
        test_done;
    end

    // *************************************************************
    // main sequence
    // *************************************************************
    initial begin
        sys_clk = 1'b0;
        {rst_b, go, host_wake_event, status_change, status_tx_ready} = 0;
        status_in = 7'h00;
        frame_bytes = 48'h0000_0000_0000;
        n_bytes = 3'h6;
        seen = 7'h00;
        bad_f = '{48'hC404_8000_0000, 48'hC305_8000_0000,
            fr(8'h40, 8'h00, 8'h00, 8'h00), fr(8'h81, 8'h00, 8'h00, 8'h00),
            fr(8'hC1, 8'h20, 8'h8A, 8'h00), fr(8'h25, 8'hAB, 8'hCD, 8'h1F)};
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        chk_val({pulses, power_down_request, wake_out_pin_b,
            status_tx_valid}, 32'h0000_0002);
        send(fr(8'h80, 8'h00, 8'hC1, 8'h00), 3'h6, 7'h60);
        chk_val(power_down_request, 32'h0000_0001);
        send(fr(8'h80, 8'h5A, 8'h3E, 8'hFF), 3'h6, 7'h00);
        chk_val(power_down_request, 32'h0000_0000);
        host_wake_event = 1'b1;
        @(posedge sys_clk) #1 host_wake_event = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk_val(wake_out_pin_b, 32'h0000_0000);
        send(fr(8'h80, 8'h00, 8'h01, 8'h00), 3'h6, 7'h20);
        chk_val(wake_out_pin_b, 32'h0000_0001);
        send(fr(8'h25, 8'hAB, 8'hCD, 8'h1F), 3'h6, 7'h10);
        chk_val({cfg_write, cfg_reg_addr, cfg_data, cfg_phy_addr},
            {5'h00, 1'b1, 5'h05, 16'hABCD, 5'h1F});
        send(fr(8'h1A, 8'h12, 8'h34, 8'hE3), 3'h6, 7'h10);
        chk_val({cfg_write, cfg_reg_addr, cfg_data, cfg_phy_addr},
            {5'h00, 1'b0, 5'h1A, 16'h1234, 5'h03});
        send(fr(8'hC0, 8'h20, 8'h8A, 8'h00), 3'h6, 7'h08);
        chk_val(ack_echo, 32'h0000_006A);
        send(fr(8'hC0, 8'h00, 8'h15, 8'h00), 3'h6, 7'h08);
        chk_val(ack_echo, 32'h0000_0015);
        // refused headers, flags and reserved bits, then a frame cut short
        for (int i = 0; i < 6; i++) begin
            send(bad_f[i], (i == 5) ? 3'h5 : 3'h6,
                (i == 5) ? 7'h00 : 7'h04);
        end
        // status acknowledged before its timeout runs out
        n_sends = 0;
        kick(7'h6A);
        for (int k = 0; k < 10 && status_tx_valid !== 1'b1; k++) begin
            @(posedge sys_clk) #1;
        end
        chk_val(status_tx_data, 32'h0000_006A);
        status_tx_ready = 1'b1;
        @(posedge sys_clk) #1 status_tx_ready = 1'b0;
        send(fr(8'hC0, 8'h20, 8'h8A, 8'h00), 3'h6, 7'h0A);
        chk_val(n_sends, 32'h0000_0001);
        // never acknowledged: first send plus 32 resends, then dropped
        n_sends = 0;
        seen = 7'h00;
        status_tx_ready = 1'b1;
        kick(7'h15);
        for (int k = 0; k < 2000 && seen[0] !== 1'b1; k++) begin
            @(posedge sys_clk) #1;
        end
        status_tx_ready = 1'b0;
        chk_val(n_sends, 32'h0000_0021);
        chk_pulse(seen, 7'h01);
        test_done;
    end
endmodule : smd_msg_decoder_bench
`default_nettype wire
